// File: hdl/srp_defines.svh
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Frame timing, counted in serial clock rising edges
`define SRP_FRAME_BITS 6'h18
`define SRP_READ_BITS 6'h30
`define SRP_OUT_LOAD 6'h20
`define SRP_CNT_MAX 6'h3F
`define SRP_CNT_STEP 6'h01

////////////////////////////////////////////////////////////////////////////////
// Register numbers as carried in the frame
`define SRP_NUM_REGS 7
`define SRP_REG_ENABLES 5'h01
`define SRP_REG_GAIN 5'h03
`define SRP_REG_BIAS 5'h04
`define SRP_REG_MIX_I 5'h05
`define SRP_REG_MIX_Q 5'h06
`define SRP_REG_POINTER 5'h07
`define SRP_REG_PHASE_I 5'h08
`define SRP_REG_PHASE_Q 5'h09

////////////////////////////////////////////////////////////////////////////////
// Reset values and fixed fields
`define SRP_RST_ENABLES 16'hD9FA
`define SRP_RST_DEFAULT 16'h0000
`define SRP_RST_PTR 5'h00
`define SRP_PTR_PAD 11'h000
`define SRP_CHIP_ADDR 3'h0
// Power switches at reset, exactly as the enable register reset value decodes, common mode buffer off included
`define SRP_RST_POWER 11'h6DA
// Reset level of select, clock and data pins, all high, loaded into the synchroniser
`define SRP_PIN_IDLE 3'h7

`endif

// File: hdl/srp_pkg.sv
package srp_pkg;

  // Frame as shifted in, first bit received sits at the top
  typedef struct packed {
    logic [2:0] chip;
    logic [4:0] num;
    logic [15:0] data;
  } srp_frame_s;

  // Layout of the block enable register
  typedef struct packed {
    logic [2:0] spare;
    logic if_log_detector_on;
    logic diff_to_single_on;
    logic diag_hi;
    logic common_mode_buffer_on;
    logic diag_lo;
    logic rf_log_detector_on;
    logic square_detector_on;
    logic envelope_off;
    logic vga_on;
    logic image_reject_mixer_on;
    logic iq_line_on;
    logic step_gain_amp_on;
    logic lowpass_filter_on;
  } srp_enables_s;

  // Power switches handed to the analog blocks, all active high
  typedef struct packed {
    logic if_log_detector_on;
    logic diff_to_single_on;
    logic common_mode_buffer_on;
    logic rf_log_detector_on;
    logic square_detector_on;
    logic envelope_detector_on;
    logic vga_on;
    logic image_reject_mixer_on;
    logic iq_line_on;
    logic step_gain_amp_on;
    logic lowpass_filter_on;
  } srp_power_s;

  // Gray coded along idle, shift, commit
  typedef enum logic [1:0] {
    SRP_IDLE = 2'h0,
    SRP_SHIFT = 2'h1,
    SRP_COMMIT = 2'h3
  } srp_state_e;

endpackage

// File: hdl/srp_port.sv
`timescale 1ns/10ps
`include "srp_defines.svh"

// Summary of operation
// - Seven 16-bit configuration registers; each frame touches at most one.
// - Frame starts on select falling; data sampled on serial clock rising edges.
// - Frame carries 3-bit chip address, 5-bit register number, 16-bit value.
// - Select rising after the 24th pulse loads the value into the register.
// - After pointer write, the read frame shifts selected register out serially.
// - Enable bit 12 switches IF log detector, active high, resets one.
// - Enable bit 11 switches differential-to-single amplifier, active high, resets one.
// - Bits 7 and 6 switch RF log and square detectors, active high.
// - Bit 5 envelope detector inverted sense; bit 4 VGA active high.
// - Bit 3 switches the image reject mixer, active high, resets one.
// - Bits 2, 1, 0 switch IQ line, step gain amp, lowpass filter.

module srp_port
  import srp_pkg::*;
#(
  parameter logic [2:0] CHIP_ADDR = `SRP_CHIP_ADDR  // Address this device answers to
) (
  input wire logic clk_i,  // System clock, 125 MHz
  input wire logic nrst_i,  // Asynchronous reset, active low
  input wire logic serial_enable_n_i,  // Frame select pin, active low
  input wire logic serial_clk_i,  // Serial clock pin from host
  input wire logic serial_data_in_i,  // Serial data pin from host
  output logic serial_data_out_o,  // Read-back data pin
  output srp_power_s power_o,  // Registered block power switches
  output logic [`SRP_NUM_REGS*16-1:0] regs_o  // All registers, entry 0 lowest
);

  localparam int NREG = `SRP_NUM_REGS;
  localparam logic [4:0] REG_NUM [NREG] = '{
    `SRP_REG_ENABLES, `SRP_REG_GAIN, `SRP_REG_BIAS, `SRP_REG_MIX_I,
    `SRP_REG_MIX_Q, `SRP_REG_PHASE_I, `SRP_REG_PHASE_Q};
  localparam logic [15:0] REG_RST [NREG] = '{
    `SRP_RST_ENABLES, `SRP_RST_DEFAULT, `SRP_RST_DEFAULT, `SRP_RST_DEFAULT,
    `SRP_RST_DEFAULT, `SRP_RST_DEFAULT, `SRP_RST_DEFAULT};

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [2:0] pins_s;
  logic sen_s, sclk_s, sdi_s;
  logic sen_d, sclk_d, next_sen_d, next_sclk_d;
  logic sclk_rise, sen_fall, sen_rise;

  // Host pins come from another clock domain
  srp_sync #(
    .WIDTH(3),
    .RST_VAL(`SRP_PIN_IDLE)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({serial_enable_n_i, serial_clk_i, serial_data_in_i}),
    .sync_o(pins_s)
  );

  // Split the synchronised pins
  assign sen_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // One cycle of history to find edges
  always_comb begin
    next_sen_d = sen_s;
    next_sclk_d = sclk_s;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sen_d <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      sen_d <= next_sen_d;
      sclk_d <= next_sclk_d;
    end
  end

  // Edges, a few system cycles behind the pins, well inside a 40 ns half period
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sen_fall = ~sen_s & sen_d;
  assign sen_rise = sen_s & ~sen_d;

  //////////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  srp_state_e state, next_state;
  logic [5:0] bit_cnt, next_bit_cnt, cnt_inc;
  srp_frame_s frame, next_frame;
  logic rd_frame, next_rd_frame, armed, next_armed;
  logic [4:0] read_ptr, next_read_ptr;
  logic [15:0] rd_word, next_rd_word, rd_data;
  logic commit_wr, commit_ptr, frame_ok;

  // Saturate so a runaway clock cannot wrap back to a legal count
  assign cnt_inc = (bit_cnt == `SRP_CNT_MAX) ? bit_cnt : bit_cnt + `SRP_CNT_STEP;

  // A write frame needs exactly 24 pulses and our chip address
  assign frame_ok = (bit_cnt == `SRP_FRAME_BITS) && (frame.chip == CHIP_ADDR)
    && !rd_frame;

  // Next frame state; the read word is loaded once the command phase is past
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_frame = frame;
    next_rd_frame = rd_frame;
    next_armed = armed;
    next_read_ptr = read_ptr;
    next_rd_word = rd_word;
    commit_wr = 1'b0;
    commit_ptr = 1'b0;
    unique case (state)
      SRP_IDLE: begin
        if (sen_fall) begin
          next_state = SRP_SHIFT;
          next_bit_cnt = 6'h00;
          next_rd_frame = armed;
          next_rd_word = `SRP_RST_DEFAULT;
        end
      end
      SRP_SHIFT: begin
        if (sen_rise) begin
          next_state = SRP_COMMIT;
        end else if (sclk_rise) begin
          next_bit_cnt = cnt_inc;
          next_frame = srp_frame_s'({frame[22:0], sdi_s});
          if (rd_frame && (cnt_inc == `SRP_OUT_LOAD)) begin
            next_rd_word = rd_data;
          end else if (rd_frame && (cnt_inc > `SRP_OUT_LOAD)
                       && (cnt_inc < `SRP_READ_BITS)) begin
            next_rd_word = {rd_word[14:0], 1'b0};
          end
        end
      end
      SRP_COMMIT: begin
        next_state = SRP_IDLE;
        next_rd_word = `SRP_RST_DEFAULT;
        if (rd_frame) begin
          next_armed = 1'b0;
        end else if (frame_ok && (frame.num == `SRP_REG_POINTER)) begin
          commit_ptr = 1'b1;
          next_read_ptr = frame.data[15:11];
          next_armed = 1'b1;
        end else if (frame_ok) begin
          commit_wr = 1'b1;
          next_armed = 1'b0;
        end
      end
      default: begin
        next_state = SRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= SRP_IDLE;
      bit_cnt <= 6'h00;
      frame <= srp_frame_s'(24'h000000);
      rd_frame <= 1'b0;
      armed <= 1'b0;
      read_ptr <= `SRP_RST_PTR;
      rd_word <= `SRP_RST_DEFAULT;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      frame <= next_frame;
      rd_frame <= next_rd_frame;
      armed <= next_armed;
      read_ptr <= next_read_ptr;
      rd_word <= next_rd_word;
    end
  end

  // Read data goes out from the top of a flop, so the host sees a stable bit
  assign serial_data_out_o = rd_word[15];

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [15:0] reg_val [NREG];
  logic [NREG-1:0] wr_vec;

  // One entry per register number; at most one matches a frame
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    logic [15:0] next_val;
    assign wr_vec[i] = commit_wr && (frame.num == REG_NUM[i]);
    always_comb begin
      next_val = wr_vec[i] ? frame.data : reg_val[i];
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        reg_val[i] <= REG_RST[i];
      end else begin
        reg_val[i] <= next_val;
      end
    end
    assign regs_o[i*16 +: 16] = reg_val[i];
  end

  // Unmapped numbers read back as zero; the pointer reads as its five written bits over zero padding
  always_comb begin
    rd_data = `SRP_RST_DEFAULT;
    if (read_ptr == `SRP_REG_POINTER) begin
      rd_data = {read_ptr, `SRP_PTR_PAD};
    end
    for (int k = 0; k < NREG; k++) begin
      if (REG_NUM[k] == read_ptr) begin
        rd_data = reg_val[k];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power switches

  srp_enables_s en;
  srp_power_s next_power;

  assign en = srp_enables_s'(reg_val[0]);

  // Diagnostic bits are stored only; software keeps them at their safe values
  always_comb begin
    next_power.if_log_detector_on = en.if_log_detector_on;
    next_power.diff_to_single_on = en.diff_to_single_on;
    next_power.common_mode_buffer_on = en.common_mode_buffer_on;
    next_power.rf_log_detector_on = en.rf_log_detector_on;
    next_power.square_detector_on = en.square_detector_on;
    next_power.envelope_detector_on = ~en.envelope_off;
    next_power.vga_on = en.vga_on;
    next_power.image_reject_mixer_on = en.image_reject_mixer_on;
    next_power.iq_line_on = en.iq_line_on;
    next_power.step_gain_amp_on = en.step_gain_amp_on;
    next_power.lowpass_filter_on = en.lowpass_filter_on;
  end

  // Registered so the analog side never sees a decode glitch
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_o <= srp_power_s'(`SRP_RST_POWER);
    end else begin
      power_o <= next_power;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_one_reg;
    @(posedge clk_i) disable iff (!nrst_i)
      commit_wr |-> $onehot0(wr_vec) ##1 (state == SRP_IDLE) && !commit_wr;
  endproperty
  a_one_reg: assert property (p_one_reg) else $error("More than one register written");
  property p_capture;
    @(posedge clk_i) disable iff (!nrst_i)
      (state == SRP_SHIFT) && sclk_rise && !sen_rise
      |=> (frame.data[0] == $past(sdi_s)) && (bit_cnt != $past(bit_cnt)
           || bit_cnt == `SRP_CNT_MAX);
  endproperty
  a_capture: assert property (p_capture) else $error("Serial bit not captured");
  property p_write_fields;
    @(posedge clk_i) disable iff (!nrst_i)
      commit_wr |-> (bit_cnt == `SRP_FRAME_BITS) && (frame.chip == CHIP_ADDR)
        && (frame.num != `SRP_REG_POINTER);
  endproperty
  a_write_fields: assert property (p_write_fields) else $error("Write on a bad frame");
  property p_load;
    @(posedge clk_i) disable iff (!nrst_i)
      wr_vec[0] |=> (reg_val[0] == $past(frame.data));
  endproperty
  a_load: assert property (p_load) else $error("Enable register not loaded");
  property p_read_load;
    @(posedge clk_i) disable iff (!nrst_i)
      (state == SRP_SHIFT) && sclk_rise && !sen_rise && rd_frame
        && (cnt_inc == `SRP_OUT_LOAD)
      |=> (serial_data_out_o == $past(rd_data[15])) && (rd_word == $past(rd_data));
  endproperty
  a_read_load: assert property (p_read_load) else $error("Read word not presented");
  property p_msb_first;
    @(posedge clk_i) disable iff (!nrst_i)
      (state == SRP_SHIFT) && sclk_rise && !sen_rise && rd_frame
        && (cnt_inc > `SRP_OUT_LOAD) && (cnt_inc < `SRP_READ_BITS)
      |=> serial_data_out_o == $past(rd_word[14]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("Read bit out of order");
  property p_foreign;
    @(posedge clk_i) disable iff (!nrst_i)
      (state == SRP_COMMIT) && (frame.chip != CHIP_ADDR)
      |-> !commit_wr && !commit_ptr ##1 $stable(read_ptr) && (wr_vec == '0);
  endproperty
  a_foreign: assert property (p_foreign) else $error("Foreign frame changed state");
  property p_if_log;
    @(posedge clk_i) disable iff (!nrst_i)
      wr_vec[0] |-> ##2 power_o.if_log_detector_on == $past(frame.data[12], 2)
        && power_o.diff_to_single_on == $past(frame.data[11], 2);
  endproperty
  a_if_log: assert property (p_if_log) else $error("IF detector switch wrong");
  property p_detectors;
    @(posedge clk_i) disable iff (!nrst_i)
      wr_vec[0] |-> ##2 power_o.rf_log_detector_on == $past(frame.data[7], 2)
        && power_o.square_detector_on == $past(frame.data[6], 2)
        && power_o.common_mode_buffer_on == $past(frame.data[9], 2);
  endproperty
  a_detectors: assert property (p_detectors) else $error("Detector switch wrong");

  property p_envelope;
    @(posedge clk_i) disable iff (!nrst_i)
      wr_vec[0] |-> ##2 power_o.envelope_detector_on != $past(frame.data[5], 2)
        && power_o.vga_on == $past(frame.data[4], 2);
  endproperty
  a_envelope: assert property (p_envelope) else $error("Envelope sense wrong");

  property p_low_bits;
    @(posedge clk_i) disable iff (!nrst_i)
      wr_vec[0] |-> ##2 power_o.image_reject_mixer_on == $past(frame.data[3], 2)
        && {power_o.iq_line_on, power_o.step_gain_amp_on, power_o.lowpass_filter_on}
           == $past(frame.data[2:0], 2);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("Low enable bits wrong");

  c_write_enables: cover property (@(posedge clk_i) disable iff (!nrst_i) wr_vec[0]);
  c_pointer: cover property (@(posedge clk_i) disable iff (!nrst_i) commit_ptr);
  c_read_done: cover property (@(posedge clk_i) disable iff (!nrst_i)
    (state == SRP_COMMIT) && rd_frame && (bit_cnt == `SRP_READ_BITS));
  c_foreign: cover property (@(posedge clk_i) disable iff (!nrst_i)
    (state == SRP_COMMIT) && (frame.chip != CHIP_ADDR));

endmodule

// File: hdl/srp_sync.sv
`timescale 1ns/10ps

module srp_sync
  import srp_pkg::*;
#(
  parameter int WIDTH = 3,  // Number of pins synchronised
  parameter logic [WIDTH-1:0] RST_VAL = '1  // Idle level of each pin
) (
  input wire logic clk_i,  // System clock
  input wire logic nrst_i,  // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_i,  // Pins from outside the domain
  output logic [WIDTH-1:0] sync_o  // Second stage, safe to read
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // Two stages per pin; only the second stage is ever read
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  // Resets to the pins' idle level so no false edge follows reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta <= next_meta;
      sync_o <= next_sync;
    end
  end

endmodule

// File: test/srp_host.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Host controller on the far side of the three-wire port
module srp_host (
  input wire logic clk_i,  // System clock, paces the link
  output logic serial_enable_n_o,  // Frame select, active low
  output logic serial_clk_o,  // Serial clock, still between frames
  output logic serial_data_in_o,  // Serial data towards the device
  input wire logic serial_data_out_i  // Read-back data from the device
);
  // Five system cycles per half period gives the fixed 80 ns bench link period;
  // faster than the host's ceiling on purpose, to stress the pin sampling margin
  localparam int HALF = 5;

  initial begin
    serial_enable_n_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_data_in_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One framed transfer; the clock idles low so no stray rising edge is seen
  task automatic frame(input logic [23:0] bits, input int pulses, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clk_i);
    serial_enable_n_o <= 1'b0;
    for (int i = 0; i < pulses; i++) begin
      // Past the 24 input bits the line toggles so no stale value lingers
      serial_data_in_o <= (i < 24) ? bits[23 - i] : ~serial_data_in_o;
      wait_clk(HALF);
      serial_clk_o <= 1'b1;
      if (i >= 32) begin
        rd = {rd[14:0], serial_data_out_i};
      end
      wait_clk(HALF);
      serial_clk_o <= 1'b0;
    end
    wait_clk(HALF);
    serial_enable_n_o <= 1'b1;
    serial_data_in_o <= ~serial_data_in_o;
    wait_clk(HALF);
  endtask

  // Register write: exactly 24 bits and 24 pulses
  task automatic write_reg(input logic [2:0] chip, input logic [4:0] num, input logic [15:0] d);
    logic [15:0] unused;
    frame({chip, num, d}, 24, unused);
  endtask

  // Pointer write first, then the 48-pulse read frame
  task automatic read_reg(input logic [2:0] chip, input logic [4:0] num, output logic [15:0] rd);
    logic [15:0] unused;
    frame({chip, 5'h07, num, 11'h000}, 24, unused);
    frame({chip, 5'h00, 16'h0000}, 48, rd);
  endtask
endmodule

// File: test/srp_port_tb.sv
`timescale 1ns/10ps
`include "srp_defines.svh"

module srp_port_tb
  import srp_pkg::*;
;
  localparam logic [2:0] ADDR = 3'h5;
  localparam int LIMIT = 30000;
  localparam logic [4:0] NUMS [7] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09};
  localparam logic [15:0] PATS [4] = '{16'h0000, 16'hFFFF, 16'hA5C3, 16'h0100};

  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic serial_enable_n;
  logic serial_clk;
  logic serial_data_in;
  logic serial_data_out;
  srp_power_s power;
  logic [`SRP_NUM_REGS*16-1:0] regs;
  logic [15:0] exp_regs [7];
  logic [15:0] rd;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #4 clk_i = ~clk_i;

  srp_port #(.CHIP_ADDR(ADDR)) srp_port_i (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .serial_enable_n_i(serial_enable_n),
    .serial_clk_i(serial_clk),
    .serial_data_in_i(serial_data_in),
    .serial_data_out_o(serial_data_out),
    .power_o(power),
    .regs_o(regs)
  );

  srp_host srp_host_i (
    .clk_i(clk_i),
    .serial_enable_n_o(serial_enable_n),
    .serial_clk_o(serial_clk),
    .serial_data_in_o(serial_data_in),
    .serial_data_out_i(serial_data_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Envelope bit is inverted sense, the two diagnostic bits have no switch
  function automatic logic [15:0] exp_power(input logic [15:0] e);
    return {5'h00, e[12], e[11], e[9], e[7], e[6], ~e[5], e[4], e[3], e[2], e[1], e[0]};
  endfunction

  // Whole register file must match the model after each write_reg and short frame, and once after the reads
  task automatic check_regs;
    for (int k = 0; k < 7; k++) begin
      check(regs[k*16 +: 16], exp_regs[k]);
    end
    check(16'(power), exp_power(exp_regs[0]));
  endtask

  task automatic settle;
    repeat (6) @(posedge clk_i);
  endtask

  // A hang is cut short here and counted as a mismatch
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    exp_regs = '{16'hD9FA, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check_regs();
    check({15'h0000, serial_data_out}, 16'h0000);
    $display("test reset done");

    // Every enable bit both ways, then the normal diagnostic setting last
    for (int p = 0; p < 4; p++) begin
      srp_host_i.write_reg(ADDR, 5'h01, PATS[p]);
      exp_regs[0] = PATS[p];
      settle();
      check_regs();
    end
    $display("test enables done");

    for (int k = 1; k < 7; k++) begin
      exp_regs[k] = {3'h0, NUMS[k], 8'hC3} ^ 16'h8421;
      srp_host_i.write_reg(ADDR, NUMS[k], exp_regs[k]);
      settle();
      check_regs();
    end
    $display("test register file done");

    // Foreign chip address, short frame and unmapped number change nothing
    srp_host_i.write_reg(3'h2, 5'h01, 16'h1234);
    settle();
    check_regs();
    srp_host_i.frame({ADDR, 5'h01, 16'h1234}, 23, rd);
    settle();
    check_regs();
    srp_host_i.write_reg(ADDR, 5'h02, 16'h1234);
    settle();
    check_regs();
    $display("test refusals done");

    // Read back every register and the pointer itself
    for (int k = 0; k < 7; k++) begin
      srp_host_i.read_reg(ADDR, NUMS[k], rd);
      check(rd, exp_regs[k]);
    end
    srp_host_i.read_reg(ADDR, 5'h07, rd);
    check(rd, 16'h3800);
    settle();
    check({15'h0000, serial_data_out}, 16'h0000);
    check_regs();
    $display("test reads done");
    test_done();
  end
endmodule
